// [verilog/pbo_regs.vh]
// Register map, field layout and datapath constants for the black offset and shift stage
`ifndef PBO_REGS_VH
`define PBO_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PBO_ADDR_W        4
`define PBO_OFS_SELECT    4'h0
`define PBO_OFS_VALUE     4'h4
`define PBO_OFS_SHIFT     4'h8
`define PBO_OFS_FORMAT    4'hC

// ----------------------------------------
// Fields and limits
// ----------------------------------------
`define PBO_SEL_GLOBAL    2'h0
`define PBO_SEL_TAP1      2'h1
`define PBO_SEL_TAP2      2'h2
`define PBO_LEVEL_MAX     10'h258
`define PBO_SHIFT_MAX     3'h4
`define PBO_LEVEL_W       10
`define PBO_SAMPLE_W      12
`define PBO_COL_W         12
`define PBO_FMT_8BIT      1'b1
`define PBO_RST_LEVEL     10'h000
`define PBO_RST_SHIFT     3'h0
`define PBO_RST_SELECT    2'h0
`define PBO_RST_FORMAT    1'b0
`define PBO_HALF_COLUMN   12'h0140

`endif

// [verilog/pbo_pixel_black_offset_shift.v]
// Pixel black offset plus digital left shift stage with Avalon-MM registers
`timescale 1ns/1ps
`include "pbo_regs.vh"

module pbo_pixel_black_offset_shift #(
  parameter [`PBO_COL_W-1:0] HALF_COLUMN = `PBO_HALF_COLUMN
) (
  clk_sys,
  rst,
  avsAddress,
  avsRead,
  avsWrite,
  avsWriteData,
  avsByteEnable,
  avsReadData,
  avsWaitRequest,
  pixInValid,
  pixInData,
  pixInColumn,
  pixOutValid,
  pixOutData
);
  input  wire                    clk_sys;        // System clock, 40 MHz
  input  wire                    rst;            // Synchronous reset, active high
  input  wire [`PBO_ADDR_W-1:0]  avsAddress;     // Byte address
  input  wire                    avsRead;        // Read strobe
  input  wire                    avsWrite;       // Write strobe
  input  wire [31:0]             avsWriteData;   // Write data
  input  wire [3:0]              avsByteEnable;  // Byte lanes
  output reg  [31:0]             avsReadData;    // Read data
  output wire                    avsWaitRequest; // Stall until answer cycle
  input  wire                    pixInValid;     // Sample valid
  input  wire [`PBO_SAMPLE_W-1:0] pixInData;     // Raw ADC sample
  input  wire [`PBO_COL_W-1:0]   pixInColumn;    // Column of sample
  output reg                     pixOutValid;    // Result valid
  output reg  [`PBO_SAMPLE_W-1:0] pixOutData;    // Result pixel

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg [1:0]              offset_target_select_reg; // Which level the value port reaches
  reg [`PBO_LEVEL_W-1:0] levelGlobal_reg;          // Global black level
  reg [`PBO_LEVEL_W-1:0] levelTap1_reg;            // Right half extra
  reg [`PBO_LEVEL_W-1:0] levelTap2_reg;            // Left half extra
  reg [2:0]              pixel_left_shift_amount_reg; // Shift 0..4
  reg                    format8_reg;              // High selects eight-bit format
  reg                    ack_reg;                  // Answer cycle marker

  // Access accepted on second cycle of a request
  wire accessReq = (avsRead | avsWrite) & ~ack_reg;
  assign avsWaitRequest = accessReq;
  wire doWrite = avsWrite & ack_reg & avsByteEnable[0];

  // Clip an offset write to the legal range
  function [`PBO_LEVEL_W-1:0] clipLevel;
    input [31:0] v;
    begin
      if (v > {22'h0, `PBO_LEVEL_MAX}) begin
        clipLevel = `PBO_LEVEL_MAX;
      end else begin
        clipLevel = v[`PBO_LEVEL_W-1:0];
      end
    end
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Selector chooses target of the shared value port
  always @(posedge clk_sys) begin
    if (rst) begin
      ack_reg                     <= 1'b0;
      offset_target_select_reg    <= `PBO_RST_SELECT;
      levelGlobal_reg             <= `PBO_RST_LEVEL;
      levelTap1_reg               <= `PBO_RST_LEVEL;
      levelTap2_reg               <= `PBO_RST_LEVEL;
      pixel_left_shift_amount_reg <= `PBO_RST_SHIFT;
      format8_reg                 <= `PBO_RST_FORMAT;
    end else begin
      ack_reg <= accessReq;
      if (doWrite) begin
        case (avsAddress)
          `PBO_OFS_SELECT: begin
            // Code 3 ignored; bits above 1..0 not decoded
            if (avsWriteData[1:0] != 2'h3) begin
              offset_target_select_reg <= avsWriteData[1:0];
            end
          end
          `PBO_OFS_VALUE: begin
            case (offset_target_select_reg)
              `PBO_SEL_GLOBAL: levelGlobal_reg <= clipLevel(avsWriteData);
              `PBO_SEL_TAP1:   levelTap1_reg   <= clipLevel(avsWriteData);
              `PBO_SEL_TAP2:   levelTap2_reg   <= clipLevel(avsWriteData);
              default:         levelGlobal_reg <= levelGlobal_reg;
            endcase
          end
          `PBO_OFS_SHIFT: begin
            // Out of range shift values ignored
            if (avsWriteData[2:0] <= `PBO_SHIFT_MAX && avsWriteData[31:3] == 29'h0) begin
              pixel_left_shift_amount_reg <= avsWriteData[2:0];
            end
          end
          `PBO_OFS_FORMAT: format8_reg <= avsWriteData[0];
          default: format8_reg <= format8_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Value port reads back the selected level; unmapped reads zero
  always @(posedge clk_sys) begin
    if (rst) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead & accessReq) begin
      case (avsAddress)
        `PBO_OFS_SELECT: avsReadData <= {30'h0, offset_target_select_reg};
        `PBO_OFS_VALUE: begin
          case (offset_target_select_reg)
            `PBO_SEL_TAP1: avsReadData <= {22'h0, levelTap1_reg};
            `PBO_SEL_TAP2: avsReadData <= {22'h0, levelTap2_reg};
            default:       avsReadData <= {22'h0, levelGlobal_reg};
          endcase
        end
        `PBO_OFS_SHIFT:  avsReadData <= {29'h0, pixel_left_shift_amount_reg};
        `PBO_OFS_FORMAT: avsReadData <= {31'h0, format8_reg};
        default:         avsReadData <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Black offset datapath
  // ----------------------------------------
  // Right half columns use tap one, left half tap two
  wire                    rightHalf = (pixInColumn >= HALF_COLUMN);
  wire [`PBO_LEVEL_W-1:0] tapLevel  = rightHalf ? levelTap1_reg : levelTap2_reg;
  // Eleven-bit sum covers 1023 and beyond without wrap
  wire [`PBO_LEVEL_W:0]   levelSum  = {1'b0, levelGlobal_reg} + {1'b0, tapLevel};
  // Four level units per count in the twelve-bit scale; eight-bit scale is the same
  // offset seen after dropping four bits, giving 64 units per eight-bit count
  wire [`PBO_SAMPLE_W-1:0] offsetCounts = {3'h0, levelSum[`PBO_LEVEL_W:2]};
  wire [`PBO_SAMPLE_W:0]  offsetSum = {1'b0, pixInData} + {1'b0, offsetCounts};
  // Saturate on overflow; never wraps
  wire [`PBO_SAMPLE_W-1:0] corrected = offsetSum[`PBO_SAMPLE_W] ? {`PBO_SAMPLE_W{1'b1}}
                                      : offsetSum[`PBO_SAMPLE_W-1:0];

  // ----------------------------------------
  // Digital shift with saturation
  // ----------------------------------------
  reg [`PBO_SAMPLE_W-1:0] shifted; // Shifted pixel
  reg                     lostTop; // A discarded top bit was set
  always @* begin
    case (pixel_left_shift_amount_reg)
      3'h1: begin
        shifted = {corrected[10:0], 1'b0};
        lostTop = corrected[11];
      end
      3'h2: begin
        shifted = {corrected[9:0], 2'b00};
        lostTop = |corrected[11:10];
      end
      3'h3: begin
        shifted = {corrected[8:0], 3'b000};
        lostTop = |corrected[11:9];
      end
      3'h4: begin
        shifted = {corrected[7:0], 4'h0};
        lostTop = |corrected[11:8];
      end
      default: begin
        shifted = corrected;
        lostTop = 1'b0;
      end
    endcase
  end

  // Output register; eight-bit format carries its value in bits 11..4
  always @(posedge clk_sys) begin
    if (rst) begin
      pixOutValid <= 1'b0;
      pixOutData  <= 12'h000;
    end else begin
      pixOutValid <= pixInValid;
      if (pixInValid) begin
        pixOutData <= lostTop ? {`PBO_SAMPLE_W{1'b1}} : shifted;
      end
    end
  end

endmodule

// [testbench/pbo_pixel_black_offset_shift_properties.sv]
// Port checks for the black offset and shift stage
`timescale 1ns/1ps
`include "pbo_regs.vh"
module pbo_offset_shift_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        pixInValid,
  input wire logic [11:0] pixInData,
  input wire logic        pixOutValid,
  input wire logic [11:0] pixOutData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rdAck = avsRead && !avsWaitRequest;  // Read answered this cycle
  // Bus answer in two steps: one stall, then the answer
  sequence waitCycle; avsWaitRequest; endsequence
  sequence answerCycle; !avsWaitRequest; endsequence
  a_one_wait_state: assert property ($rose(avsRead || avsWrite) |-> waitCycle ##1 answerCycle)
    else $error("bus answer not after one wait cycle");
  a_valid_latency: assert property (pixInValid |=> pixOutValid)
    else $error("pixel result missing");
  a_idle_hold: assert property (!pixInValid |=> !pixOutValid && $stable(pixOutData))
    else $error("pixel output moved without input");
  a_full_scale: assert property (pixInValid && pixInData == 12'hFFF |=> pixOutData == 12'hFFF)
    else $error("full scale sample not all ones");
  a_level_limit: assert property (rdAck && avsAddress == `PBO_OFS_VALUE |-> avsReadData <= 32'h0000_0258)
    else $error("offset level above limit");
  a_shift_limit: assert property (rdAck && avsAddress == `PBO_OFS_SHIFT |-> avsReadData <= 32'h0000_0004)
    else $error("shift amount above four");
  a_select_range: assert property (rdAck && avsAddress == `PBO_OFS_SELECT |-> avsReadData < 32'h0000_0003)
    else $error("selector holds a fourth choice");
  a_unmapped_zero: assert property (rdAck && avsAddress[1:0] != 2'h0 |-> avsReadData == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind pbo_pixel_black_offset_shift pbo_offset_shift_props i_pbo_offset_shift_props (
  .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .pixInValid(pixInValid),
  .pixInData(pixInData), .pixOutValid(pixOutValid), .pixOutData(pixOutData));

// [testbench/pbo_adc_model.sv]
// Behavioural twelve-bit sample source in place of the sensor converters
`timescale 1ns/1ps
module pbo_adc_model (
  input  wire logic        clk_sys,
  output logic             pixInValid,
  output logic [11:0]      pixInData,
  output logic [11:0]      pixInColumn
);
  initial begin
    pixInValid = 1'b0;
    pixInData = 12'h000;
    pixInColumn = 12'h000;
  end
  // One sample per call; data is scrambled once it has been taken
  task automatic send(input logic [11:0] d, input logic [11:0] c);
    pixInValid <= 1'b1;
    pixInData <= d;
    pixInColumn <= c;
    @(posedge clk_sys);
    pixInValid <= 1'b0;
    pixInData <= ~d;
  endtask
endmodule

// [testbench/test_pixel_black_offset_shift.sv]
// Bench for the black offset and shift stage
`timescale 1ns/1ps
`include "pbo_regs.vh"
module test_pixel_black_offset_shift;
  logic        clk_sys, rst, avsRead, avsWrite, avsWaitRequest, pixInValid, pixOutValid;
  logic [3:0]  avsAddress, avsByteEnable;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [11:0] pixInData, pixInColumn, pixOutData;
  logic [9:0]  lvl [3];  // Expected global, tap one, tap two
  logic [2:0]  shf;      // Expected shift amount
  int          errors, checks_done;
  pbo_pixel_black_offset_shift i_pbo_pixel_black_offset_shift (
    .clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .pixInValid(pixInValid),
    .pixInData(pixInData), .pixInColumn(pixInColumn), .pixOutValid(pixOutValid),
    .pixOutData(pixOutData));
  pbo_adc_model i_pbo_adc_model (.clk_sys(clk_sys), .pixInValid(pixInValid),
    .pixInData(pixInData), .pixInColumn(pixInColumn));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle held until the stall drops; read data land in rd
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic setlvl(input logic [1:0] sel, input logic [9:0] v);
    bus(1'b1, `PBO_OFS_SELECT, {30'h0, sel});
    bus(1'b1, `PBO_OFS_VALUE, {22'h0, v});
    lvl[sel] = v;
  endtask
  // One sample through the stage, result worked out from the offsets and shift
  task automatic pix(input logic [11:0] d, input logic [11:0] c);
    logic [12:0] s;
    s = d + ((lvl[0] + (c >= `PBO_HALF_COLUMN ? lvl[1] : lvl[2])) >> 2);
    if (s > 13'h0FFF) s = 13'h0FFF;
    i_pbo_adc_model.send(d, c);
    #1;
    check(pixOutValid, 1'b1);
    check(pixOutData, (shf != 0 && (s[11:0] >> (12 - shf)) != 0) ? 12'hFFF : s[11:0] << shf);
    @(posedge clk_sys);
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    avsByteEnable = 4'hF;
    lvl = '{default: 10'h000};
    shf = 3'h0;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, `PBO_OFS_SHIFT, 32'h0);
    check(rd, 32'h0000_0000);
    setlvl(2'h0, 10'h008);
    setlvl(2'h2, 10'h000);
    setlvl(2'h1, 10'h004);
    bus(1'b0, `PBO_OFS_VALUE, 32'h0);
    check(rd, 32'h0000_0004);
    bus(1'b1, `PBO_OFS_SELECT, 32'h0000_0003);
    bus(1'b0, `PBO_OFS_SELECT, 32'h0);
    check(rd, 32'h0000_0001);
    bus(1'b1, 4'h2, 32'h0000_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0000_0000);
    for (int k = 0; k <= 4; k++) begin
      bus(1'b1, `PBO_OFS_SHIFT, 32'(k));
      shf = k[2:0];
      pix(12'h0F0, `PBO_HALF_COLUMN - 12'h001);
      pix(12'h0F0, `PBO_HALF_COLUMN);
      pix(12'(12'h800 >> (k == 0 ? 0 : k - 1)), 12'h000);
    end
    bus(1'b1, `PBO_OFS_SHIFT, 32'h0000_0005);
    bus(1'b0, `PBO_OFS_SHIFT, 32'h0);
    check(rd, 32'h0000_0004);
    bus(1'b1, `PBO_OFS_SHIFT, 32'h0);
    shf = 3'h0;
    setlvl(2'h1, 10'h000);
    setlvl(2'h0, 10'h259);
    lvl[0] = 10'h258;
    bus(1'b0, `PBO_OFS_VALUE, 32'h0);
    check(rd, 32'h0000_0258);
    pix(12'hF00, `PBO_HALF_COLUMN);
    pix(12'hFFF, 12'h000);
    bus(1'b1, `PBO_OFS_FORMAT, 32'h0000_0001);
    bus(1'b0, `PBO_OFS_FORMAT, 32'h0);
    check(rd, 32'h0000_0001);
    pix(12'h040, 12'h000);
    report_and_stop();
  end
endmodule
